// File: core/rio_csr_map.svh
// Offsets, field positions, reset values and timing counts of the
// maintenance register bank.
// Assumes a 10 MHz core clock and word aligned byte offsets.
//
// Operation
// - Reserved bits are read-only and always read back as zero.
// - Target capability flags are read-only bits 13-10, 8-4 and 2-0.
// - Address width code 001b, 010b or 100b selects 34, 50, 66 bits.
// - Upper base register is read-only, zero reset, fields masked by mode.
// - Lower base register read-only; bit 31 reserved in 34-bit mode.
// - Ident holds small ID in 23:16 and large ID in 15:0.
// - Host ID field 15:0 resets to FFFFh and locks once written.
// - Component label is plain 32-bit storage with no hardware effect.
// - Port block header is fixed: next pointer high, type code low.
// - Link timeout field 31:8 counts 205 ns steps; zero disables. The code rounds each step up to 3 clocks, 300 ns.
// - Response timeout is 15 times prescale plus one times field.
// - Response prescale comes from the peripheral settings register.
// - Role bit 31 set marks host, clear marks agent.
// - With request permission bit 30 clear, no request is issued.
// - Bit 29 records that the configuring host found this device.
`ifndef RIO_CSR_MAP_SVH
`define RIO_CSR_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_FEATURE_CAPS     16'h1010
`define OFS_TARGET_OPS_CAPS  16'h101C
`define OFS_ADDR_WIDTH_CTL   16'h104C
`define OFS_CFG_BASE_UPPER   16'h1058
`define OFS_CFG_BASE_LOWER   16'h105C
`define OFS_OWN_DEVICE_IDENT 16'h1060
`define OFS_HOST_IDENT_LOCK  16'h1068
`define OFS_COMPONENT_LABEL  16'h106C
`define OFS_PORT_BLOCK_HDR   16'h1100
`define OFS_LINK_TIMEOUT     16'h1120
`define OFS_RESP_TIMEOUT     16'h1124
`define OFS_PORT_ROLE_CTL    16'h113C

// ----------------------------------------------------------------
// Field values and masks
// ----------------------------------------------------------------
`define CAPS_VALID_MASK      32'h00003DF7
`define AW_34                3'h1
`define AW_50                3'h2
`define AW_66                3'h4
`define UPPER_66_MASK        31'h7FFF8000
`define UPPER_50_MASK        31'h00007FFF
`define LOWER_BIT35          31
`define FEAT_LARGE_BIT       4
`define ROLE_HOST_BIT        31
`define ROLE_MASTER_BIT      30
`define ROLE_FOUND_BIT       29
`define HOST_UNLOCKED        16'hFFFF

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_FEATURE_CAPS     32'h20000009
`define RST_ADDR_WIDTH       3'h1
`define RST_IDENT            24'hFFFFFF
`define RST_TIMEOUT          24'hFFFFFF
`define RST_ROLE             3'h0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS        100
`define LINK_STEP_NS         205
`define LINK_STEP_CYC        ((`LINK_STEP_NS+`CLK_PERIOD_NS-1)/`CLK_PERIOD_NS)
`define RESP_STEP_MULT       15

`endif

// File: core/rio_csr_pkg.sv
// Types shared by the maintenance register bank.
// Assumes nothing of its surroundings.
package rio_csr_pkg;

  // Register bus request
  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } csr_req_t;

  // Timer start and stop events
  typedef struct packed {
    logic start;
    logic stop;
  } tmr_evt_t;

  // Timer state
  typedef enum logic {
    TMR_IDLE,
    TMR_RUN
  } tmr_state_t;

endpackage

// File: core/rapidio_maintenance_csrs.sv
// Maintenance register bank with link and response timers.
// Assumes a same-clock register master and same-clock timer events.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ns
`include "rio_csr_map.svh"
`default_nettype none

module rapidio_maintenance_csrs #(
  parameter logic [31:0] CAPS        = 32'h00003DF4,
  parameter logic [31:0] FEAT        = `RST_FEATURE_CAPS,
  parameter logic [30:0] CFG_BASE_HI = 31'h00000000,
  parameter logic [31:0] CFG_BASE_LO = 32'h00000000,
  parameter logic [15:0] NEXT_PTR    = 16'h0000,
  parameter logic [15:0] BLOCK_TYPE  = 16'h0001
) (
  // Clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_resetn,
  // Register bus
  input  wire rio_csr_pkg::csr_req_t i_bus,
  output logic [31:0]                o_rdata,
  // Peripheral settings prescale
  input  wire logic [3:0]            i_prescale,
  // Timer events, index 0 link, 1 response
  input  wire rio_csr_pkg::tmr_evt_t i_tmr_link,
  input  wire rio_csr_pkg::tmr_evt_t i_tmr_resp,
  output logic                       o_link_expired,
  output logic                       o_resp_expired,
  // Request gating
  input  wire logic                  i_req,
  output logic                       o_req_grant,
  // Control state
  output logic                       o_host,
  output logic                       o_master_en,
  output logic                       o_discovered,
  output logic [2:0]                 o_addr_mode,
  output logic [7:0]                 o_small_id,
  output logic [15:0]                o_large_id,
  output logic                       o_large_id_valid,
  output logic [15:0]                o_host_id,
  output logic                       o_host_locked
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [2:0]  aw_ff;
  logic [23:0] ident_ff;
  logic [15:0] host_ff;
  logic [31:0] label_ff;
  logic [23:0] link_to_ff;
  logic [23:0] resp_to_ff;
  logic [2:0]  role_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic        grant_ff;
  logic        large_ok_ff;
  logic        locked_ff;

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  logic wr_aw;
  logic wr_ident;
  logic wr_host;
  logic wr_label;
  logic wr_link;
  logic wr_resp;
  logic wr_role;

  assign wr_aw    = i_bus.wr && (i_bus.addr == `OFS_ADDR_WIDTH_CTL);
  assign wr_ident = i_bus.wr && (i_bus.addr == `OFS_OWN_DEVICE_IDENT);
  assign wr_host  = i_bus.wr && (i_bus.addr == `OFS_HOST_IDENT_LOCK);
  assign wr_label = i_bus.wr && (i_bus.addr == `OFS_COMPONENT_LABEL);
  assign wr_link  = i_bus.wr && (i_bus.addr == `OFS_LINK_TIMEOUT);
  assign wr_resp  = i_bus.wr && (i_bus.addr == `OFS_RESP_TIMEOUT);
  assign wr_role  = i_bus.wr && (i_bus.addr == `OFS_PORT_ROLE_CTL);

  // ----------------------------------------------------------------
  // Address width control
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      aw_ff <= `RST_ADDR_WIDTH;
    end else if (wr_aw) begin
      if (i_bus.wdata[2:0] == `AW_34 ||
          i_bus.wdata[2:0] == `AW_50 ||
          i_bus.wdata[2:0] == `AW_66) begin
        aw_ff <= i_bus.wdata[2:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Device identifiers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ident_ff <= `RST_IDENT;
    end else if (wr_ident) begin
      ident_ff <= i_bus.wdata[23:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      large_ok_ff <= 1'b0;
    end else begin
      large_ok_ff <= FEAT[`FEAT_LARGE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Host identifier lock
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      host_ff <= `HOST_UNLOCKED;
    end else if (wr_host) begin
      if (host_ff == `HOST_UNLOCKED) begin
        host_ff <= i_bus.wdata[15:0];
      end else if (i_bus.wdata[15:0] == host_ff) begin
        host_ff <= `HOST_UNLOCKED;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      locked_ff <= 1'b0;
    end else if (wr_host) begin
      if (host_ff == `HOST_UNLOCKED) begin
        locked_ff <= (i_bus.wdata[15:0] != `HOST_UNLOCKED);
      end else if (i_bus.wdata[15:0] == host_ff) begin
        locked_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Component label
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      label_ff <= 32'h00000000;
    end else if (wr_label) begin
      label_ff <= i_bus.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Timeout controls
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      link_to_ff <= `RST_TIMEOUT;
    end else if (wr_link) begin
      link_to_ff <= i_bus.wdata[31:8];
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      resp_to_ff <= `RST_TIMEOUT;
    end else if (wr_resp) begin
      resp_to_ff <= i_bus.wdata[31:8];
    end
  end

  // ----------------------------------------------------------------
  // Port role control
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      role_ff <= `RST_ROLE;
    end else if (wr_role) begin
      role_ff[2] <= i_bus.wdata[`ROLE_HOST_BIT];
      role_ff[1] <= i_bus.wdata[`ROLE_MASTER_BIT];
      role_ff[0] <= i_bus.wdata[`ROLE_FOUND_BIT];
    end
  end

  // Requests pass only with permission
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      grant_ff <= 1'b0;
    end else begin
      grant_ff <= i_req && role_ff[1];
    end
  end

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------
  logic [30:0] upper_mask;
  logic        lower_top_ok;

  always_comb begin
    upper_mask = 31'h00000000;
    if (aw_ff == `AW_66) begin
      upper_mask = `UPPER_66_MASK | `UPPER_50_MASK;
    end else if (aw_ff == `AW_50) begin
      upper_mask = `UPPER_50_MASK;
    end
  end

  assign lower_top_ok = (aw_ff != `AW_34);

  always_comb begin
    nxt_rdata = 32'h00000000;
    if (i_bus.rd) begin
      unique case (i_bus.addr)
        `OFS_FEATURE_CAPS: begin
          nxt_rdata = FEAT;
        end
        `OFS_TARGET_OPS_CAPS: begin
          nxt_rdata = CAPS & `CAPS_VALID_MASK;
        end
        `OFS_ADDR_WIDTH_CTL: begin
          nxt_rdata = {29'h00000000, aw_ff};
        end
        `OFS_CFG_BASE_UPPER: begin
          nxt_rdata = {1'b0, CFG_BASE_HI & upper_mask};
        end
        `OFS_CFG_BASE_LOWER: begin
          nxt_rdata = CFG_BASE_LO;
          nxt_rdata[`LOWER_BIT35] = CFG_BASE_LO[`LOWER_BIT35]
                                    & lower_top_ok;
        end
        `OFS_OWN_DEVICE_IDENT: begin
          nxt_rdata = {8'h00, ident_ff};
        end
        `OFS_HOST_IDENT_LOCK: begin
          nxt_rdata = {16'h0000, host_ff};
        end
        `OFS_COMPONENT_LABEL: begin
          nxt_rdata = label_ff;
        end
        `OFS_PORT_BLOCK_HDR: begin
          nxt_rdata = {NEXT_PTR, BLOCK_TYPE};
        end
        `OFS_LINK_TIMEOUT: begin
          nxt_rdata = {link_to_ff, 8'h00};
        end
        `OFS_RESP_TIMEOUT: begin
          nxt_rdata = {resp_to_ff, 8'h00};
        end
        `OFS_PORT_ROLE_CTL: begin
          nxt_rdata = {role_ff, 29'h00000000};
        end
        default: begin
          nxt_rdata = 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_ff <= 32'h00000000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  localparam logic [7:0] LINK_LIMIT = 8'(`LINK_STEP_CYC - 1);

  logic [7:0]              resp_limit;
  logic [7:0]              step_limit [2];
  logic [23:0]             tmr_value  [2];
  rio_csr_pkg::tmr_evt_t   tmr_evt    [2];
  rio_csr_pkg::tmr_state_t st_ff      [2];
  logic [7:0]              pre_ff     [2];
  logic [23:0]             tk_ff      [2];
  logic                    exp_ff     [2];

  // Response step from peripheral settings prescale
  assign resp_limit = 8'(`RESP_STEP_MULT * ({4'h0, i_prescale} + 8'h01))
                      - 8'h01;

  assign step_limit[0] = LINK_LIMIT;
  assign step_limit[1] = resp_limit;
  assign tmr_value[0]  = link_to_ff;
  assign tmr_value[1]  = resp_to_ff;
  assign tmr_evt[0]    = i_tmr_link;
  assign tmr_evt[1]    = i_tmr_resp;

  for (genvar g = 0; g < 2; g++) begin : g_tmr
    always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        st_ff[g]  <= rio_csr_pkg::TMR_IDLE;
        pre_ff[g] <= 8'h00;
        tk_ff[g]  <= 24'h000000;
        exp_ff[g] <= 1'b0;
      end else begin
        exp_ff[g] <= 1'b0;
        unique case (st_ff[g])
          rio_csr_pkg::TMR_IDLE: begin
            if (tmr_evt[g].start && tmr_value[g] != 24'h000000) begin
              st_ff[g]  <= rio_csr_pkg::TMR_RUN;
              pre_ff[g] <= 8'h00;
              tk_ff[g]  <= 24'h000000;
            end
          end
          rio_csr_pkg::TMR_RUN: begin
            if (tmr_evt[g].stop || tmr_value[g] == 24'h000000) begin
              st_ff[g] <= rio_csr_pkg::TMR_IDLE;
            end else if (tmr_evt[g].start) begin
              pre_ff[g] <= 8'h00;
              tk_ff[g]  <= 24'h000000;
            end else if (pre_ff[g] >= step_limit[g]) begin
              pre_ff[g] <= 8'h00;
              if (tk_ff[g] + 24'h000001 >= tmr_value[g]) begin
                exp_ff[g] <= 1'b1;
                st_ff[g]  <= rio_csr_pkg::TMR_IDLE;
              end else begin
                tk_ff[g] <= tk_ff[g] + 24'h000001;
              end
            end else begin
              pre_ff[g] <= pre_ff[g] + 8'h01;
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_rdata          = rdata_ff;
  assign o_link_expired   = exp_ff[0];
  assign o_resp_expired   = exp_ff[1];
  assign o_req_grant      = grant_ff;
  assign o_host           = role_ff[2];
  assign o_master_en      = role_ff[1];
  assign o_discovered     = role_ff[0];
  assign o_addr_mode      = aw_ff;
  assign o_small_id       = ident_ff[23:16];
  assign o_large_id       = ident_ff[15:0];
  assign o_large_id_valid = large_ok_ff;
  assign o_host_id        = host_ff;
  assign o_host_locked    = locked_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_reserved_zero: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    i_bus.rd && i_bus.addr == `OFS_HOST_IDENT_LOCK
    |=> o_rdata[31:16] == 16'h0000)
    else $error("Reserved host lock bits read nonzero");

  a_caps_fixed: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    i_bus.rd && i_bus.addr == `OFS_TARGET_OPS_CAPS
    |=> o_rdata == (CAPS & `CAPS_VALID_MASK))
    else $error("Capability read wrong");

  a_addr_mode_legal: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    o_addr_mode == `AW_34 || o_addr_mode == `AW_50 ||
    o_addr_mode == `AW_66)
    else $error("Address width code illegal");

  a_upper_mode_mask: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    i_bus.rd && i_bus.addr == `OFS_CFG_BASE_UPPER && aw_ff != `AW_66
    |=> o_rdata[31:15] == 17'h00000)
    else $error("Upper base field visible outside 66-bit mode");

  a_lower_top_bit: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    i_bus.rd && i_bus.addr == `OFS_CFG_BASE_LOWER && aw_ff == `AW_34
    |=> !o_rdata[31])
    else $error("Lower base bit 31 set in 34-bit mode");

  a_ident_write: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    wr_ident |=> o_small_id == $past(i_bus.wdata[23:16]) &&
                 o_large_id == $past(i_bus.wdata[15:0]))
    else $error("Ident write not stored");

  a_host_lock_hold: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    wr_host && host_ff != `HOST_UNLOCKED &&
    i_bus.wdata[15:0] != host_ff |=> $stable(o_host_id))
    else $error("Locked host ID changed");

  a_host_unlock: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    wr_host && host_ff != `HOST_UNLOCKED &&
    i_bus.wdata[15:0] == host_ff |=> o_host_id == `HOST_UNLOCKED)
    else $error("Host lock not released");

  a_header_fixed: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    i_bus.rd && i_bus.addr == `OFS_PORT_BLOCK_HDR
    |=> o_rdata == {NEXT_PTR, BLOCK_TYPE})
    else $error("Block header read wrong");

  a_link_disabled: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    link_to_ff == 24'h000000 && $past(link_to_ff) == 24'h000000
    |-> !o_link_expired)
    else $error("Disabled link timer expired");

  a_role_write: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    wr_role |=> o_host == $past(i_bus.wdata[31]) &&
                o_discovered == $past(i_bus.wdata[29]))
    else $error("Role bits not stored");

  a_req_gate: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    !o_master_en && !wr_role |=> !o_req_grant)
    else $error("Request granted without permission");

endmodule

`default_nettype wire

// File: sim/host_model.sv
// Remote host model: register accesses and enumeration steps.
// Assumes the bench clock; released lines show the inverse value.
`timescale 1ns/1ns
`include "rio_csr_map.svh"
`default_nettype none

module host_model (
  // Clock
  input  wire logic                 i_clk,
  // Register bus
  output var rio_csr_pkg::csr_req_t o_bus,
  input  wire logic [31:0]          i_rdata
);
  // ----------------------------------------
  // Bus cycles
  // ----------------------------------------
  initial o_bus = '0;

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge i_clk);
    o_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk);
    o_bus <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask

  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge i_clk);
    o_bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk);
    o_bus <= '{addr: ~a, wdata: 32'hFFFFFFFF, wr: 1'b0, rd: 1'b0};
    #1;
    d = i_rdata;
  endtask

  // Claim the device, then mark it found
  task automatic enumerate(input logic [15:0] id, output logic [31:0] d);
    rd(`OFS_HOST_IDENT_LOCK, d);
    if (d[15:0] === `HOST_UNLOCKED) begin
      wr(`OFS_HOST_IDENT_LOCK, {16'h0, id});
    end
    wr(`OFS_PORT_ROLE_CTL, 32'h20000000);
    rd(`OFS_HOST_IDENT_LOCK, d);
  endtask
endmodule
`default_nettype wire

// File: sim/rapidio_maintenance_csrs_bench.sv
// Testbench of the maintenance register bank.
// Assumes host_model drives the register port.
`timescale 1ns/1ns
`include "rio_csr_map.svh"
`default_nettype none

module rapidio_maintenance_csrs_bench;
  // ----------------------------------------
  // Signals and design
  // ----------------------------------------
  logic                  i_clk;
  logic                  i_resetn;
  rio_csr_pkg::csr_req_t i_bus;
  logic [31:0]           o_rdata;
  logic [3:0]            i_prescale;
  rio_csr_pkg::tmr_evt_t i_tmr_link;
  rio_csr_pkg::tmr_evt_t i_tmr_resp;
  logic                  o_link_expired;
  logic                  o_resp_expired;
  logic                  i_req;
  logic                  o_req_grant;
  logic                  o_host;
  logic                  o_master_en;
  logic                  o_discovered;
  logic [2:0]            o_addr_mode;
  logic [7:0]            o_small_id;
  logic [15:0]           o_large_id;
  logic                  o_large_id_valid;
  logic [15:0]           o_host_id;
  logic                  o_host_locked;
  logic [31:0]           d;
  logic [2:0]            m;
  int                    n_fail = 0;
  int                    cmp_count = 0;
  logic [15:0] map_a [13] = '{16'h1010, 16'h101C, 16'h104C, 16'h1058,
    16'h105C, 16'h1060, 16'h1068, 16'h106C, 16'h1100, 16'h1120,
    16'h1124, 16'h113C, 16'h1064};
  logic [31:0] rst_v [13] = '{32'h20000009, 32'h00003DF4, 32'h00000001,
    32'h0, 32'h07654320, 32'h00FFFFFF, 32'h0000FFFF, 32'h0,
    32'h02000002, 32'hFFFFFF00, 32'hFFFFFF00, 32'h0, 32'h0};
  logic [31:0] one_v [13] = '{32'h20000009, 32'h00003DF4, 32'h00000001,
    32'h0, 32'h07654320, 32'h00FFFFFF, 32'h0000FFFF, 32'hFFFFFFFF,
    32'h02000002, 32'hFFFFFF00, 32'hFFFFFF00, 32'hE0000000, 32'h0};

  rapidio_maintenance_csrs #(
    .CFG_BASE_HI (31'h7FFFFFFF),
    .CFG_BASE_LO (32'h87654320),
    .NEXT_PTR    (16'h0200),
    .BLOCK_TYPE  (16'h0002)
  ) i_dut (
    .i_clk, .i_resetn, .i_bus, .o_rdata, .i_prescale, .i_tmr_link,
    .i_tmr_resp, .o_link_expired, .o_resp_expired, .i_req, .o_req_grant,
    .o_host, .o_master_en, .o_discovered, .o_addr_mode, .o_small_id,
    .o_large_id, .o_large_id_valid, .o_host_id, .o_host_locked
  );

  host_model i_host (.i_clk(i_clk), .o_bus(i_bus), .i_rdata(o_rdata));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  initial i_clk = 1'b0;
  always #50 i_clk = ~i_clk;

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp1(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic chk_rd(input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] v;
    i_host.rd(a, v);
    cmp32(v, exp);
  endtask

  // Start a timer, optionally stop it, count cycles to expiry
  task automatic run_tmr(input bit resp, input bit stop, input int exp);
    int n;
    logic hit;
    @(posedge i_clk);
    if (resp) i_tmr_resp <= '{start: 1'b1, stop: 1'b0};
    else i_tmr_link <= '{start: 1'b1, stop: 1'b0};
    @(posedge i_clk);
    i_tmr_resp <= '{start: 1'b0, stop: stop & resp};
    i_tmr_link <= '{start: 1'b0, stop: stop & ~resp};
    n = 0;
    hit = 1'b0;
    while (n < 120 && !hit) begin
      @(posedge i_clk);
      i_tmr_resp <= '0;
      i_tmr_link <= '0;
      #1;
      n++;
      hit = resp ? (o_resp_expired === 1'b1) : (o_link_expired === 1'b1);
    end
    if (exp == 0) cmp1(hit, 1'b0);
    else cmp1(n == exp, 1'b1);
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge i_clk);
    n_fail++;
    $display("[ERR] %0t watchdog expired", $time);
    end_of_test();
  end

  initial begin
    i_resetn = 1'b0;
    i_prescale = 4'h0;
    i_tmr_link = '0;
    i_tmr_resp = '0;
    i_req = 1'b0;
    repeat (5) @(posedge i_clk);
    i_resetn <= 1'b1;
    for (int i = 0; i < 13; i++) chk_rd(map_a[i], rst_v[i]);
    for (int i = 0; i < 13; i++) i_host.wr(map_a[i], 32'hFFFFFFFF);
    for (int i = 0; i < 13; i++) chk_rd(map_a[i], one_v[i]);
    m = 3'h1;
    for (int c = 0; c < 8; c++) begin
      i_host.wr(`OFS_ADDR_WIDTH_CTL, 32'hFFFFFFF8 | 32'(c));
      if (c == 1 || c == 2 || c == 4) m = 3'(c);
      chk_rd(`OFS_ADDR_WIDTH_CTL, {29'h0, m});
      cmp32({29'h0, o_addr_mode}, {29'h0, m});
      d = m == 3'h4 ? 32'h7FFFFFFF : m == 3'h2 ? 32'h00007FFF : 32'h0;
      chk_rd(`OFS_CFG_BASE_UPPER, d);
      d = m == 3'h1 ? 32'h07654320 : 32'h87654320;
      chk_rd(`OFS_CFG_BASE_LOWER, d);
    end
    i_host.wr(`OFS_OWN_DEVICE_IDENT, 32'hFF123456);
    chk_rd(`OFS_OWN_DEVICE_IDENT, 32'h00123456);
    cmp32({8'h0, o_small_id, o_large_id}, 32'h00123456);
    cmp1(o_large_id_valid, 1'b0);
    i_host.wr(`OFS_COMPONENT_LABEL, 32'hDEADBEEF);
    chk_rd(`OFS_COMPONENT_LABEL, 32'hDEADBEEF);
    for (int b = 0; b < 3; b++) begin
      i_host.wr(`OFS_PORT_ROLE_CTL, (32'h80000000 >> b) | 32'h1FFFFFFF);
      chk_rd(`OFS_PORT_ROLE_CTL, 32'h80000000 >> b);
      cmp32({29'h0, o_host, o_master_en, o_discovered}, 32'h4 >> b);
    end
    i_host.wr(`OFS_PORT_ROLE_CTL, 32'h0);
    i_req <= 1'b1;
    repeat (3) @(posedge i_clk);
    #1;
    cmp1(o_req_grant, 1'b0);
    i_host.wr(`OFS_PORT_ROLE_CTL, 32'h40000000);
    repeat (2) @(posedge i_clk);
    #1;
    cmp1(o_req_grant, 1'b1);
    i_host.enumerate(16'h0042, d);
    cmp32(d, 32'h00000042);
    cmp1(o_host_locked, 1'b1);
    cmp1(o_discovered, 1'b1);
    i_host.wr(`OFS_HOST_IDENT_LOCK, 32'h00000055);
    chk_rd(`OFS_HOST_IDENT_LOCK, 32'h00000042);
    i_host.wr(`OFS_HOST_IDENT_LOCK, 32'h00000042);
    chk_rd(`OFS_HOST_IDENT_LOCK, 32'h0000FFFF);
    cmp1(o_host_locked, 1'b0);
    i_host.wr(`OFS_HOST_IDENT_LOCK, 32'h00000077);
    chk_rd(`OFS_HOST_IDENT_LOCK, 32'h00000077);
    cmp32({16'h0, o_host_id}, 32'h00000077);
    i_host.wr(`OFS_LINK_TIMEOUT, 32'h000002FF);
    chk_rd(`OFS_LINK_TIMEOUT, 32'h00000200);
    run_tmr(1'b0, 1'b0, 6);
    i_host.wr(`OFS_LINK_TIMEOUT, 32'h00000100);
    run_tmr(1'b0, 1'b0, 3);
    run_tmr(1'b0, 1'b1, 0);
    i_host.wr(`OFS_LINK_TIMEOUT, 32'h0);
    run_tmr(1'b0, 1'b0, 0);
    i_host.wr(`OFS_RESP_TIMEOUT, 32'h000002AA);
    chk_rd(`OFS_RESP_TIMEOUT, 32'h00000200);
    run_tmr(1'b1, 1'b0, 30);
    @(posedge i_clk);
    i_prescale <= 4'h2;
    i_host.wr(`OFS_RESP_TIMEOUT, 32'h00000100);
    run_tmr(1'b1, 1'b0, 45);
    run_tmr(1'b1, 1'b1, 0);
    end_of_test();
  end
endmodule
`default_nettype wire
